/* design/btt_defs.vh */
// constants for the bus trace trigger/capture block
// assumes inclusion by bare name from design files
`ifndef BTT_DEFS_VH
`define BTT_DEFS_VH
`define BTT_REC_W 80
`define BTT_DEPTH 4096
`define BTT_ADDR_W 12
`define BTT_FIFO_DEPTH 32
`define BTT_CLK_MHZ 25
`define BTT_US_NS 1000
`define BTT_CLK_NS 40
`define BTT_US_CYC (`BTT_US_NS / `BTT_CLK_NS)
`define BTT_UNIT_ROLL 1000
// record field positions (lsb)
`define BTT_F_DATA 0
`define BTT_F_PADDR 16
`define BTT_F_LPAGE 40
`define BTT_F_PTAB 46
`define BTT_F_LEVEL 50
`define BTT_F_PON 54
`define BTT_F_ION 55
`define BTT_F_ALT 56
`define BTT_F_IFETCH 57
`define BTT_F_DMA 58
`define BTT_F_WRITE 59
`define BTT_F_IOX 60
`define BTT_F_TIME 64
// trace control word bits
`define BTT_C_RUN 0
`define BTT_C_STOPHOST 1
`define BTT_C_TRIG_ON_STOP 2
`define BTT_C_LOGICAL 3
`define BTT_C_DELAYED 4
`endif

/* design/btt_fifo.v */
// synchronous fifo with valid/ready on both sides
// assumes one clock and active-low synchronous reset
`timescale 1ns/100ps
module btt_fifo #(
	parameter WIDTH = 80,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk_sys, // clock
	input wire resetn, // sync reset, active low
	input wire [WIDTH-1:0] in_data, // write data
	input wire in_valid, // write request
	output wire in_ready, // not full
	output wire [WIDTH-1:0] out_data, // head word
	output wire out_valid, // not empty
	input wire out_ready // drain accepts
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wp_q;
	reg [AW:0] rp_q;
	wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	wire empty = (wp_q == rp_q);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rp_q[AW-1:0]];
	// pointer carry bit tells full from empty
	always @(posedge clk_sys) begin
		if (!resetn) begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wp_q <= wp_q + 1'b1;
			if (out_ready && !empty)
				rp_q <= rp_q + 1'b1;
		end
	end
	// storage has no reset
	always @(posedge clk_sys) begin
		if (in_valid && !full)
			mem[wp_q[AW-1:0]] <= in_data;
	end
endmodule

/* design/btt_core.v */
// bus trace, trigger and capture core
// assumes the host bus strobe arrives from a pin; memory-management fields are latched on it
`timescale 1ns/100ps
`include "btt_defs.vh"
module btt_core #(
	parameter DEPTH = `BTT_DEPTH,
	parameter AW = `BTT_ADDR_W,
	parameter FDEPTH = `BTT_FIFO_DEPTH
) (
	input wire clk_sys, // 25 MHz clock
	input wire resetn, // sync reset, active low
	input wire cyc_strobe, // host bus cycle done (pin)
	input wire cyc_refresh, // cycle is refresh
	input wire io_transfer_cycle, // cycle is io transfer
	input wire cyc_dma, // dma originated
	input wire cyc_write, // write access
	input wire [23:0] bus_paddr, // physical address
	input wire [15:0] bus_data, // data lines
	input wire [15:0] mmb_laddr, // memory_management_bus logical address
	input wire [5:0] mmb_lpage, // logical page
	input wire [3:0] mmb_ptab, // page table
	input wire [3:0] mmb_level, // interrupt level
	input wire mmb_pon, // paging on
	input wire mmb_ion, // interrupts on
	input wire mmb_alt, // alternate table
	input wire mmb_ifetch, // instruction fetch
	input wire host_stopped, // host in stop state (pin)
	input wire [15:0] ctrl_word, // trace control word
	input wire [63:0] qual_mask, // qualifier care mask
	input wire [63:0] qual_value, // qualifier compare value
	input wire [63:0] trig_mask, // trigger care mask
	input wire [63:0] trig_value, // trigger compare value
	input wire [15:0] trig_levels, // accepted levels for trigger
	input wire [15:0] trig_post, // further records after trigger
	input wire [31:0] rtc_now, // real-time clock value
	input wire [3:0] baud_switch, // baud switch position
	input wire dma_req, // dma read request, pulse
	input wire [23:0] dma_addr, // dma target address
	input wire dma_ack, // host answers dma read (pin)
	input wire [15:0] dma_rdata, // host read data
	input wire [AW-1:0] rd_addr, // monitor read index
	input wire rec_ready, // monitor drains record stream
	output reg rec_valid, // record stream valid
	output reg [79:0] rec_data, // record stream data
	output reg [79:0] rd_data, // trace memory read data
	output reg [AW-1:0] wr_ptr, // ring write pointer
	output reg triggered, // trigger seen
	output reg capturing, // capture active
	output reg stop_req, // halt request to host
	output reg [31:0] ts_start, // start timestamp
	output reg [31:0] ts_trig, // trigger timestamp
	output reg [15:0] baud_div, // baud divisor
	output reg dma_busy, // dma in progress
	output reg dma_req_out, // dma request to host
	output reg [23:0] dma_addr_out, // dma address to host
	output reg [15:0] dma_data_q, // latched dma data
	output reg [23:0] dma_addr_q, // latched dma address
	output reg overflow // fifo refused a record
);
	// baud divisor per baud: clk/(16*baud); 134.5 rounded
	function [15:0] baud_of;
		input [3:0] pos;
		begin
			case (pos)
				4'h0: baud_of = 16'h377D; // 110
				4'h1: baud_of = 16'h28B1; // 150
				4'h2: baud_of = 16'h1458; // 300
				4'h3: baud_of = 16'h028B; // 2400
				4'h4: baud_of = 16'h0516; // 1200
				4'h5: baud_of = 16'h0364; // 1800
				4'h6: baud_of = 16'h0146; // 4800
				4'h7: baud_of = 16'h00A3; // 9600
				4'h8: baud_of = 16'h028B; // 2400
				4'h9: baud_of = 16'h0A2C; // 600
				4'hA: baud_of = 16'h1E85; // 200
				4'hB: baud_of = 16'h2D61; // 134.5
				4'hC: baud_of = 16'h5161; // 75
				4'hD: baud_of = 16'h7A12; // 50
				4'hE: baud_of = 16'h3D09; // 100
				default: baud_of = 16'h3D09; // 100
			endcase
		end
	endfunction

	// three-stage pin synchronisers; stage 1 feeds only stage 2
	reg [2:0] cs1_q, cs2_q, cs3_q;
	wire [2:0] pin_in = {dma_ack, host_stopped, cyc_strobe};
	always @(posedge clk_sys) begin
		if (!resetn) begin
			cs1_q <= 3'h0;
			cs2_q <= 3'h0;
			cs3_q <= 3'h0;
		end else begin
			cs1_q <= pin_in;
			cs2_q <= cs1_q;
			cs3_q <= cs2_q;
		end
	end
	// a change counts once stages 2 and 3 agree
	reg [2:0] pin_st_q;
	always @(posedge clk_sys) begin
		if (!resetn)
			pin_st_q <= 3'h0;
		else
			pin_st_q <= (cs2_q & cs3_q) | (pin_st_q & (cs2_q | cs3_q));
	end
	wire [2:0] pin_agree = (cs2_q & cs3_q) | (pin_st_q & (cs2_q | cs3_q));
	wire cyc_rise = pin_agree[0] & ~pin_st_q[0];
	wire stop_rise = pin_agree[1] & ~pin_st_q[1];
	wire ack_rise = pin_agree[2] & ~pin_st_q[2];

	// latch bus and memory-management fields at strobe; inputs only, never driven
	reg [63:0] lat_q;
	reg [15:0] lat_laddr_q;
	reg lat_ok_q;
	always @(posedge clk_sys) begin
		if (!resetn) begin
			lat_q <= 64'h0;
			lat_laddr_q <= 16'h0;
			lat_ok_q <= 1'b0;
		end else begin
			lat_ok_q <= cyc_rise & ~cyc_refresh;
			if (cyc_rise) begin
				lat_q <= {3'h0, io_transfer_cycle, cyc_write, cyc_dma, mmb_ifetch, mmb_alt,
					mmb_ion, mmb_pon, mmb_level, mmb_ptab, mmb_lpage, bus_paddr,
					bus_data};
				lat_laddr_q <= mmb_laddr;
			end
		end
	end

	// control decode into unit enables
	wire en_run = ctrl_word[`BTT_C_RUN];
	wire en_stophost = ctrl_word[`BTT_C_STOPHOST];
	wire en_trig_stop = ctrl_word[`BTT_C_TRIG_ON_STOP];
	wire en_logical = ctrl_word[`BTT_C_LOGICAL];
	wire en_delayed = ctrl_word[`BTT_C_DELAYED];

	// logical compare replaces the address with the zero-extended logical address on cpu cycles
	wire use_log = en_logical & ~lat_q[`BTT_F_DMA] & ~lat_q[`BTT_F_IOX];
	wire [63:0] cmp_word = use_log ?
		{lat_q[63:40], 8'h00, lat_laddr_q, lat_q[15:0]} : lat_q;
	// one shared mask structure for both units
	wire [1:0] hit;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_match
			wire [63:0] m = (gi == 0) ? qual_mask : trig_mask;
			wire [63:0] v = (gi == 0) ? qual_value : trig_value;
			assign hit[gi] = ~|((cmp_word ^ v) & m);
		end
	endgenerate
	wire lvl_ok = trig_levels[lat_q[`BTT_F_LEVEL+3:`BTT_F_LEVEL]];
	wire qual = lat_ok_q & hit[0];
	wire trig_ev = (lat_ok_q & hit[1] & lvl_ok) | (en_trig_stop & stop_rise);

	// interval timer: microsecond ticks, unit step past 1000
	reg [4:0] us_cnt_q;
	reg [15:0] ivl_q;
	reg [9:0] sub_q;
	reg [1:0] unit_q;
	wire us_tick = (us_cnt_q == (`BTT_US_CYC - 1));
	always @(posedge clk_sys) begin
		if (!resetn || qual) begin
			us_cnt_q <= 5'h00;
			ivl_q <= 16'h0000;
			sub_q <= 10'h000;
			unit_q <= 2'h0;
		end else begin
			us_cnt_q <= us_tick ? 5'h00 : us_cnt_q + 5'h01;
			if (us_tick) begin
				if (sub_q == 10'h000) begin
					if (ivl_q[13:0] == (`BTT_UNIT_ROLL - 1) && unit_q != 2'h3) begin
						unit_q <= unit_q + 2'h1;
						ivl_q <= {unit_q + 2'h1, 14'h0001};
					end else
						ivl_q <= {unit_q, ivl_q[13:0] + 14'h0001};
				end
				// each coarser unit counts once per 1000 microsecond ticks
				sub_q <= (unit_q == 2'h0 || sub_q == (`BTT_UNIT_ROLL - 1)) ?
					10'h000 : sub_q + 10'h001;
			end
		end
	end

	// trace memory, ring buffer of 80-bit records
	reg [79:0] tmem [0:DEPTH-1];
	wire [79:0] rec = {ivl_q, lat_q};
	// write only while capture and fifo can take the record, never stalling host
	wire fifo_in_ready;
	wire do_write = capturing & qual & fifo_in_ready;
	always @(posedge clk_sys) begin
		if (do_write)
			tmem[wr_ptr] <= rec;
		rd_data <= tmem[rd_addr];
	end

	// capture control, post-trigger count, halt and timestamps
	reg [15:0] post_q;
	reg run_q;
	always @(posedge clk_sys) begin
		if (!resetn) begin
			wr_ptr <= {AW{1'b0}};
			capturing <= 1'b0;
			triggered <= 1'b0;
			stop_req <= 1'b0;
			post_q <= 16'h0000;
			run_q <= 1'b0;
			ts_start <= 32'h0;
			ts_trig <= 32'h0;
			overflow <= 1'b0;
		end else begin
			run_q <= en_run;
			if (en_run && !run_q) begin
				capturing <= 1'b1;
				triggered <= 1'b0;
				stop_req <= 1'b0;
				overflow <= 1'b0;
				ts_start <= rtc_now;
			end else if (!en_run)
				capturing <= 1'b0;
			if (capturing && qual && !fifo_in_ready)
				overflow <= 1'b1;
			if (do_write)
				wr_ptr <= wr_ptr + 1'b1;
			if (capturing && !triggered && trig_ev) begin
				triggered <= 1'b1;
				ts_trig <= rtc_now;
				stop_req <= en_stophost;
				post_q <= trig_post;
				if (!en_delayed || trig_post == 16'h0000)
					capturing <= 1'b0;
			end else if (triggered && capturing && do_write) begin
				post_q <= post_q - 16'h0001;
				if (post_q == 16'h0001)
					capturing <= 1'b0;
			end
		end
	end

	// record stream through the fifo; its ready gates trace writes
	wire [79:0] f_data;
	wire f_valid;
	btt_fifo #(.WIDTH(80), .DEPTH(FDEPTH), .AW(5)) u_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.in_data(rec),
		.in_valid(do_write),
		.in_ready(fifo_in_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(rec_ready & ~rec_valid | rec_ready & rec_valid)
	);
	always @(posedge clk_sys) begin
		if (!resetn) begin
			rec_valid <= 1'b0;
			rec_data <= 80'h0;
		end else begin
			rec_valid <= f_valid & rec_ready;
			rec_data <= f_data;
		end
	end

	// baud divisor from switch
	always @(posedge clk_sys) begin
		if (!resetn)
			baud_div <= 16'h0000;
		else
			baud_div <= baud_of(baud_switch);
	end

	// dma master read
	always @(posedge clk_sys) begin
		if (!resetn) begin
			dma_busy <= 1'b0;
			dma_req_out <= 1'b0;
			dma_addr_out <= 24'h0;
			dma_data_q <= 16'h0;
			dma_addr_q <= 24'h0;
		end else if (!dma_busy) begin
			if (dma_req) begin
				dma_busy <= 1'b1;
				dma_req_out <= 1'b1;
				dma_addr_out <= dma_addr;
			end
		end else if (ack_rise) begin
			dma_busy <= 1'b0;
			dma_req_out <= 1'b0;
			dma_data_q <= dma_rdata;
			dma_addr_q <= dma_addr_out;
		end
	end
endmodule

/* test/btt_core_monitor.sv */
// assertions on btt_core ports
// assumes one clock and a sync active-low reset
`timescale 1ns/100ps
module btt_core_monitor #(parameter AW = 12) (
	input wire clk_sys, // clock
	input wire resetn, // reset
	input wire cyc_strobe, // cycle
	input wire [15:0] ctrl_word, // control
	input wire [3:0] baud_switch, // switch
	input wire dma_req, // start
	input wire [23:0] dma_addr, // target
	input wire dma_ack, // answer
	input wire [AW-1:0] wr_ptr, // pointer
	input wire triggered, // trigger
	input wire capturing, // capture
	input wire stop_req, // halt
	input wire [15:0] baud_div, // divisor
	input wire dma_busy, // busy
	input wire dma_req_out, // request
	input wire [23:0] dma_addr_out // address
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// dma: a free unit takes the request, then issues it
	sequence s_take;
		dma_req && !dma_busy;
	endsequence
	sequence s_issue;
		dma_req_out && dma_busy && dma_addr_out == $past(dma_addr);
	endsequence
	a_dma_take: assert property (s_take |=> s_issue)
		else $error("dma not issued");
	a_dma_done: assert property ($rose(dma_ack) |-> ##[1:6] !dma_busy)
		else $error("dma not finished");
	// ring pointer: single steps, only for a recent cycle
	a_ptr_quiet: assert property ((!cyc_strobe) [*8] |=> $stable(wr_ptr))
		else $error("pointer moved idle");
	a_ptr_step: assert property ($changed(wr_ptr) |-> wr_ptr == $past(wr_ptr) + 1'b1)
		else $error("pointer jumped");
	a_cap_freeze: assert property (!capturing && !$past(capturing) |-> $stable(wr_ptr))
		else $error("write after stop");
	// halt only from an enabled trigger, which then holds
	a_stop_cause: assert property ($rose(stop_req) |-> triggered && ctrl_word[1])
		else $error("halt without trigger");
	a_trig_hold: assert property (triggered && ctrl_word[0] |=> triggered)
		else $error("trigger lost");
	a_baud_nine: assert property ($past(resetn) && $stable(baud_switch) &&
		baud_switch == 4'h7 |-> baud_div == 16'h00A3) else $error("baud divisor wrong");
endmodule
bind btt_core btt_core_monitor #(.AW(AW)) u_mon (.clk_sys(clk_sys), .resetn(resetn),
	.cyc_strobe(cyc_strobe), .ctrl_word(ctrl_word), .baud_switch(baud_switch),
	.dma_req(dma_req), .dma_addr(dma_addr), .dma_ack(dma_ack), .wr_ptr(wr_ptr),
	.triggered(triggered), .capturing(capturing), .stop_req(stop_req),
	.baud_div(baud_div), .dma_busy(dma_busy), .dma_req_out(dma_req_out),
	.dma_addr_out(dma_addr_out));

/* test/btt_host_model.sv */
// host bus and dma responder
// assumes the bench calls bus_cycle by hierarchy
`timescale 1ns/100ps
module btt_host_model (
	input wire clk_sys, // clock
	input wire stop_req, // halt
	input wire dma_req_out, // dma read
	input wire [23:0] dma_addr_out, // address
	output reg cyc_strobe = 1'b0, // strobe
	output reg [63:0] cyc = 64'h0, // fields
	output reg cyc_refresh = 1'b0, // refresh
	output reg host_stopped = 1'b0, // halted
	output reg dma_ack = 1'b0, // answer
	output reg [15:0] dma_rdata = 16'h0 // data
);
	// bench-driven halt, independent of the stop request
	reg ext_halt = 1'b0;
	// fields held past capture, then scrambled so stale values cannot pass
	task bus_cycle(input [63:0] f, input r);
		begin
			@(posedge clk_sys);
			cyc <= f;
			cyc_refresh <= r;
			cyc_strobe <= 1'b1;
			repeat (6) @(posedge clk_sys);
			cyc_strobe <= 1'b0;
			repeat (2) @(posedge clk_sys);
			cyc <= ~f;
			repeat (4) @(posedge clk_sys);
		end
	endtask
	// halt follows request; dma answered a cycle late, idle data toggles
	always @(posedge clk_sys) begin
		host_stopped <= stop_req | ext_halt;
		dma_ack <= dma_req_out;
		dma_rdata <= dma_req_out ? dma_addr_out[15:0] ^ 16'h5A5A : ~dma_rdata;
	end
endmodule

/* test/btt_core_tb_top.sv */
// bench for btt_core with host model
// assumes the record field layout of the core
`timescale 1ns/100ps
module btt_core_tb_top;
	reg clk_sys = 1'b0;
	reg resetn = 1'b0;
	reg dreq = 1'b0;
	reg [15:0] ctl = 16'h0, lv = 16'hFFFF, tp = 16'h0;
	reg [63:0] qm = 64'h0, qv = 64'h0, tm = 64'h0, tv = 64'h0;
	reg [31:0] rtc = 32'h0;
	reg [23:0] dad = 24'h0;
	reg [3:0] bsw = 4'h0;
	integer err_count = 0, n_tests = 0, i;
	integer bt [0:15] = '{1100, 1500, 3000, 24000, 12000, 18000, 48000, 96000, 24000, 6000,
		2000, 1345, 750, 500, 1000, 1000};
	reg [2:0] kt [0:4] = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h3};
	wire stb, rf, hs, dack, trg, cap, sr, busy, dro;
	wire [63:0] cy;
	wire [15:0] drd, bd, dq;
	wire [79:0] rd;
	wire [31:0] tst;
	wire [23:0] dao, daq;
	wire [11:0] wp;
	wire rcv, ovf;
	wire [79:0] rcd;
	wire [31:0] tss;
	reg [79:0] last_rec = 80'h0;
	// keep the last streamed record, as rec_valid stands one cycle only
	always @(posedge clk_sys)
		if (rcv === 1'b1)
			last_rec <= rcd;
	// 40 ns period
	initial forever #20 clk_sys = ~clk_sys;
	btt_host_model m (.clk_sys(clk_sys), .stop_req(sr), .dma_req_out(dro), .dma_addr_out(dao),
		.cyc_strobe(stb), .cyc(cy), .cyc_refresh(rf), .host_stopped(hs), .dma_ack(dack),
		.dma_rdata(drd));
	btt_core DUT (.clk_sys(clk_sys), .resetn(resetn), .cyc_strobe(stb), .cyc_refresh(rf),
		.io_transfer_cycle(cy[60]), .cyc_dma(cy[58]), .cyc_write(cy[59]), .bus_data(cy[15:0]),
		.bus_paddr(cy[39:16]), .mmb_laddr(cy[31:16]), .mmb_lpage(cy[45:40]),
		.mmb_ptab(cy[49:46]), .mmb_level(cy[53:50]), .mmb_pon(cy[54]), .mmb_ion(cy[55]),
		.mmb_alt(cy[56]), .mmb_ifetch(cy[57]), .host_stopped(hs), .ctrl_word(ctl),
		.qual_mask(qm), .qual_value(qv), .trig_mask(tm), .trig_value(tv), .trig_levels(lv),
		.trig_post(tp), .rtc_now(rtc), .baud_switch(bsw), .dma_req(dreq), .dma_addr(dad),
		.dma_ack(dack), .dma_rdata(drd), .rd_addr(12'h000), .rec_ready(1'b1), .rec_valid(rcv),
		.rec_data(rcd), .rd_data(rd), .wr_ptr(wp), .triggered(trg), .capturing(cap),
		.stop_req(sr), .ts_start(tss), .ts_trig(tst), .baud_div(bd), .dma_busy(busy),
		.dma_req_out(dro), .dma_addr_out(dao), .dma_data_q(dq), .dma_addr_q(daq), .overflow(ovf));
	task ck(input string nm, input [79:0] e, input [79:0] g);
		begin
			n_tests = n_tests + 1;
			if (e !== g) begin
				err_count = err_count + 1;
				$display("[ERR] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task final_report;
		begin
			$display("%0d checks, %0d mismatches", n_tests, err_count);
			if (err_count == 0 && n_tests > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// cycle fields in record order, paging bits fixed
	function [63:0] fld(input [23:0] a, input [15:0] d, input [3:0] l, input [2:0] k);
		fld = {3'h0, k, 4'h5, l, 4'h3, 6'h15, a, d};
	endfunction
	// reset with control word cleared, so each test that sets the run bit starts a fresh run
	task rst(input [15:0] c, input [63:0] mk, input [63:0] v);
		begin
			@(posedge clk_sys);
			resetn <= 1'b0;
			ctl <= 16'h0;
			repeat (8) @(posedge clk_sys);
			resetn <= 1'b1;
			ctl <= c;
			tm <= mk;
			tv <= v;
		end
	endtask
	task t_baud;
		begin
			rst(16'h0, 64'h0, 64'h0);
			for (i = 0; i < 16; i = i + 1) begin
				bsw <= i[3:0];
				repeat (3) @(posedge clk_sys);
				ck("baud", (250000000 + 8 * bt[i]) / (16 * bt[i]), bd);
			end
			$display("baud done");
		end
	endtask
	// only dma cycles qualify; refresh is never stored; trigger needs data zero
	task t_qual;
		begin
			rst(16'h1, 64'hFFFF, 64'h0);
			qm <= 64'h1 << 58;
			qv <= 64'h1 << 58;
			m.bus_cycle(fld(24'hABCDE1, 16'h5A3C, 4'h7, 3'h1), 1'b0);
			m.bus_cycle(fld(24'hABCDE1, 16'h5A3C, 4'h7, 3'h0), 1'b0);
			m.bus_cycle(fld(24'hABCDE1, 16'h5A3C, 4'h7, 3'h1), 1'b1);
			ck("ptr", 1, wp);
			ck("rec", fld(24'hABCDE1, 16'h5A3C, 4'h7, 3'h1), {3'h0, rd[60:0]});
			ck("stream", fld(24'hABCDE1, 16'h5A3C, 4'h7, 3'h1), last_rec[63:0]);
			ck("ovf", 0, ovf);
			qm <= 64'h0;
			$display("qual done");
		end
	endtask
	// immediate stop and host halt on a write of zero to address 480A
	task t_trig;
		begin
			rst(16'h3, 64'hFF_FFFF_FFFF, 64'h480A_0000);
			rtc <= 32'h1111_0000;
			m.bus_cycle(fld(24'h480B, 16'h0, 4'h1, 3'h2), 1'b0);
			ck("trig", 0, trg);
			rtc <= 32'h1234_5678;
			m.bus_cycle(fld(24'h480A, 16'h0, 4'h1, 3'h2), 1'b0);
			ck("stop", 1, sr);
			ck("host", 1, hs);
			ck("ts", 32'h1234_5678, tst);
			ck("ts0", 32'h1111_0000, tss);
			m.bus_cycle(fld(24'h480A, 16'h0, 4'h1, 3'h2), 1'b0);
			ck("ptr", 2, wp);
			$display("trig done");
		end
	endtask
	// delayed stop: two further records after the trigger
	task t_post;
		begin
			rst(16'h11, 64'hFFFF, 64'h77);
			tp <= 16'h2;
			for (i = 0; i < 4; i = i + 1)
				m.bus_cycle(fld(24'h20, 16'h77, 4'h2, 3'h0), 1'b0);
			ck("ptr", 3, wp);
			ck("cap", 0, cap);
			tp <= 16'h0;
			$display("post done");
		end
	endtask
	// five cycle types, restricted to level 3
	task t_lvl;
		begin
			for (i = 0; i < 5; i = i + 1) begin
				rst(16'h1, 64'h7 << 58, {3'h0, kt[i], 58'h0});
				lv <= 16'h0008;
				m.bus_cycle(fld(24'h10, 16'h1, 4'h3, kt[i] ^ 3'h6), 1'b0);
				m.bus_cycle(fld(24'h10, 16'h1, 4'h5, kt[i]), 1'b0);
				ck("trig", 0, trg);
				m.bus_cycle(fld(24'h10, 16'h1, 4'h3, kt[i]), 1'b0);
				ck("trig", 1, trg);
			end
			lv <= 16'hFFFF;
			$display("level done");
		end
	endtask
	// logical compare on cpu cycles only; dma keeps the physical address
	task t_log;
		begin
			rst(16'h9, 64'hFF_FFFF_0000, 64'h1234_0000);
			m.bus_cycle(fld(24'h561234, 16'h1, 4'h1, 3'h1), 1'b0);
			ck("trig", 0, trg);
			m.bus_cycle(fld(24'h561234, 16'h1, 4'h1, 3'h0), 1'b0);
			ck("trig", 1, trg);
			$display("logical done");
		end
	endtask
	// host entering stop is itself a trigger; no halt request without its bit
	task t_hstop;
		begin
			rst(16'h5, 64'hFFFF, 64'hFFFF);
			m.ext_halt <= 1'b1;
			repeat (8) @(posedge clk_sys);
			ck("trig", 1, trg);
			ck("cap", 0, cap);
			ck("stop", 0, sr);
			m.ext_halt <= 1'b0;
			$display("host stop done");
		end
	endtask
	// dma read latches host data and address
	task t_dma;
		begin
			rst(16'h0, 64'h0, 64'h0);
			dad <= 24'hC0FFEE;
			dreq <= 1'b1;
			@(posedge clk_sys);
			dreq <= 1'b0;
			@(negedge clk_sys);
			for (i = 0; i < 50 && busy !== 1'b0; i = i + 1)
				@(negedge clk_sys);
			ck("busy", 0, busy);
			if (busy !== 1'b0)
				final_report;
			ck("dq", 16'hFFEE ^ 16'h5A5A, dq);
			ck("daq", 24'hC0FFEE, daq);
			$display("dma done");
		end
	endtask
	// main sequence
	initial begin
		t_baud;
		t_qual;
		t_trig;
		t_post;
		t_lvl;
		t_log;
		t_hstop;
		t_dma;
		final_report;
	end
endmodule
